// ---- src/pei_phy_event_irq.v ----
// PHY event interrupt control/status and auto-negotiation diagnostic registers
//
// Function
// [R1] Eight event flags live in bits 7:0 of the interrupt register, each set to one by its event.
// [R2] Reading the interrupt register clears all eight flags.
// [R3] Enable bits 15:8 each gate the flag eight positions below into the PHY interrupt.
// [R4] All key events are visible at one register address by polling.
// [R5] Bit 7 records a jabber condition, gated by enable bit 15.
// [R6] Bit 6 records a receive error, gated by enable bit 14.
// [R7] Bit 5 records arrival of a new page, gated by enable bit 13.
// [R8] Bit 4 records a parallel detection fault, gated by enable bit 12.
// [R9] Bit 3 records a burst received with acknowledge, gated by enable bit 11.
// [R10] Bit 2 records only a good-to-failed link change, gated by enable bit 10.
// [R11] Bit 1 records a partner remote fault, gated by enable bit 9.
// [R12] Bit 0 records auto-negotiation completion, gated by enable bit 8.
// [R13] The whole interrupt register resets to zero.
// [R14] Bits 31:16 read as zero and ignore writes.
// [R15] A read-only diagnostic register resets to zero and shows the last negotiation result.
// [R16] An event in the cycle of a clearing read stays set; the interrupt is the OR of enabled flags.
`timescale 1ns/1ps
`default_nettype none
`include "pei_defines.vh"

module pei_phy_event_irq #(
  parameter FLAGS = 8
) (
  input  wire        clock,
  input  wire        rst_b,
  input  wire [4:0]  reg_addr,
  input  wire        reg_read,
  input  wire        reg_write,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata_q,
  output reg         reg_rvalid_q,
  input  wire        babble_event,
  input  wire        rx_fault_event,
  input  wire        page_arrival_event,
  input  wire        parallel_detect_fault_event,
  input  wire        partner_ack_event,
  input  wire        link_good,
  input  wire        far_fault_event,
  input  wire        negotiation_done_event,
  input  wire        diag_update,
  input  wire [15:0] diag_result,
  output reg         phy_irq_q
);

  // ===================================================================
  // Decode
  function is_addr;
    input [4:0] a;
    input [4:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  wire             sel_irq  = is_addr(reg_addr, `PEI_REG_IRQ_CTRL_STATUS);
  wire             sel_diag = is_addr(reg_addr, `PEI_REG_AUTONEG_DIAG);
  wire             clear_read = reg_read & sel_irq; // [R2]
  wire             link_fail_pulse;
  wire [FLAGS-1:0] flags_q;
  wire [FLAGS-1:0] event_vec;

  reg  [FLAGS-1:0] enables_q;
  reg  [15:0]      diag_q;

  // ===================================================================
  // Event sources
  pei_link_fail_detect u_link_fail (
    .clock           (clock),
    .rst_b           (rst_b),
    .link_good       (link_good),
    .link_fail_pulse (link_fail_pulse)
  );

  assign event_vec[`PEI_BIT_BABBLE]   = babble_event;                // [R5]
  assign event_vec[`PEI_BIT_RX_FAULT] = rx_fault_event;              // [R6]
  assign event_vec[`PEI_BIT_PAGE]     = page_arrival_event;          // [R7]
  assign event_vec[`PEI_BIT_PDF]      = parallel_detect_fault_event; // [R8]
  assign event_vec[`PEI_BIT_ACK]      = partner_ack_event;           // [R9]
  assign event_vec[`PEI_BIT_LINKFAIL] = link_fail_pulse;             // [R10]
  assign event_vec[`PEI_BIT_FARFAULT] = far_fault_event;             // [R11]
  assign event_vec[`PEI_BIT_NEGDONE]  = negotiation_done_event;      // [R12]

  pei_event_flags #(
    .WIDTH (FLAGS)
  ) u_flags (
    .clock       (clock),
    .rst_b       (rst_b),
    .event_pulse (event_vec),
    .clear_read  (clear_read),
    .flags_q     (flags_q)
  );

  // ===================================================================
  // Enables and diagnostic
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      enables_q <= `PEI_ENABLE_RESET; // [R13]
      diag_q    <= `PEI_DIAG_RESET;   // [R15]
    end
    else
    begin
      // Upper half of the write word is dropped on purpose
      if (reg_write && sel_irq)
        enables_q <= reg_wdata[`PEI_ENABLE_MSB:`PEI_ENABLE_LSB]; // [R3] [R14]
      if (diag_update)
        diag_q <= diag_result; // [R15]
    end
  end

  // ===================================================================
  // Read port and interrupt
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      reg_rdata_q  <= `PEI_WORD_ZERO;
      reg_rvalid_q <= 1'b0;
      phy_irq_q    <= 1'b0;
    end
    else
    begin
      reg_rvalid_q <= reg_read;
      if (reg_read)
      begin
        if (sel_irq)
          reg_rdata_q <= {`PEI_HALF_ZERO, enables_q, flags_q}; // [R4] [R14]
        else if (sel_diag)
          reg_rdata_q <= {`PEI_HALF_ZERO, diag_q}; // [R15]
        else
          reg_rdata_q <= `PEI_WORD_ZERO;
      end
      // Uses registered flags, so interrupt trails a flag by one cycle
      phy_irq_q <= |(flags_q & enables_q); // [R3] [R16]
    end
  end

endmodule // pei_phy_event_irq
`default_nettype wire

// ---- src/pei_defines.vh ----
// Register offsets, field positions and reset values of the PHY event interrupt block
`ifndef PEI_DEFINES_VH
`define PEI_DEFINES_VH

// ===================================================================
// Register offsets (management register index)
`define PEI_REG_IRQ_CTRL_STATUS 5'h11
`define PEI_REG_AUTONEG_DIAG    5'h12

// ===================================================================
// Field positions
`define PEI_FLAG_LSB     4'h0
`define PEI_FLAG_MSB     4'h7
`define PEI_ENABLE_LSB   4'h8
`define PEI_ENABLE_MSB   4'hf
`define PEI_BIT_BABBLE   3'h7
`define PEI_BIT_RX_FAULT 3'h6
`define PEI_BIT_PAGE     3'h5
`define PEI_BIT_PDF      3'h4
`define PEI_BIT_ACK      3'h3
`define PEI_BIT_LINKFAIL 3'h2
`define PEI_BIT_FARFAULT 3'h1
`define PEI_BIT_NEGDONE  3'h0

// ===================================================================
// Reset values
`define PEI_FLAG_RESET   8'h00
`define PEI_ENABLE_RESET 8'h00
`define PEI_DIAG_RESET   16'h0000
`define PEI_WORD_ZERO    32'h0000_0000
`define PEI_HALF_ZERO    16'h0000

`endif

// ---- src/pei_event_flags.v ----
// Sticky event flags with clear-on-read where a new event wins
`timescale 1ns/1ps
`default_nettype none
`include "pei_defines.vh"

module pei_event_flags #(
  parameter WIDTH = 8
) (
  input  wire             clock,
  input  wire             rst_b,
  input  wire [WIDTH-1:0] event_pulse,
  input  wire             clear_read,
  output reg  [WIDTH-1:0] flags_q
);

  reg [WIDTH-1:0] flags_d;

  // ===================================================================
  // Flag update
  always @*
  begin
    // Set beats clear so an event coincident with the read survives
    flags_d = (clear_read ? {WIDTH{1'b0}} : flags_q) | event_pulse; // [R1] [R2] [R16]
  end

  always @(posedge clock)
  begin
    if (!rst_b)
      flags_q <= `PEI_FLAG_RESET; // [R13]
    else
      flags_q <= flags_d;
  end

endmodule // pei_event_flags
`default_nettype wire

// ---- src/pei_link_fail_detect.v ----
// Detects the good-to-failed transition of link status
`timescale 1ns/1ps
`default_nettype none

module pei_link_fail_detect (
  input  wire clock,
  input  wire rst_b,
  input  wire link_good,
  output wire link_fail_pulse
);

  reg link_good_q;

  always @(posedge clock)
  begin
    if (!rst_b)
      link_good_q <= 1'b0;
    else
      link_good_q <= link_good;
  end

  // Only a falling edge counts; link coming up raises nothing
  assign link_fail_pulse = link_good_q & ~link_good; // [R10]

endmodule // pei_link_fail_detect
`default_nettype wire

// ---- bench/pei_host.sv ----
// Host model issuing management register requests
`timescale 1ns/1ps
`default_nettype none
// ====
// Host side
module pei_host (
  input  wire logic        clock,
  input  wire logic [31:0] reg_rdata_q,
  output var  logic [4:0]  reg_addr = 5'h0,
  output var  logic        reg_read = 1'b0,
  output var  logic        reg_write = 1'b0,
  output var  logic [31:0] reg_wdata = 32'h0
);
  // Entered at an edge; the request is taken at the next one
  task wr(input logic [4:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [4:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    d = reg_rdata_q;
  endtask
endmodule // pei_host
`default_nettype wire

// ---- bench/pei_chk_sva.sv ----
// Assertion checker for the PHY event interrupt block
`timescale 1ns/1ps
`default_nettype none
// ====
// Port relations
module pei_chk (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic [4:0]  reg_addr,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata_q,
  input wire logic        reg_rvalid_q,
  input wire logic        page_arrival_event,
  input wire logic        link_good,
  input wire logic        phy_irq_q
);
  logic rd;
  assign rd = reg_read && reg_addr == 5'h11;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_rv; reg_read |=> reg_rvalid_q; endproperty
  a_rv: assert property (p_rv) else $error("no answer");
  property p_nv; !reg_read |=> !reg_rvalid_q; endproperty
  a_nv: assert property (p_nv) else $error("stray answer");
  property p_hi; reg_rvalid_q |-> reg_rdata_q[31:16] == 16'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper half");
  property p_un; reg_read && reg_addr == 5'h1f |=> reg_rdata_q == 32'h0; endproperty
  a_un: assert property (p_un) else $error("unmapped data");
  property p_pg; page_arrival_event ##1 !rd [*2] ##1 rd |=> reg_rdata_q[5]; endproperty
  a_pg: assert property (p_pg) else $error("page flag");
  property p_lk; $fell(link_good) ##1 !rd [*2] ##1 rd |=> reg_rdata_q[2]; endproperty
  a_lk: assert property (p_lk) else $error("link flag");
  property p_rs; $rose(rst_b) |-> reg_rdata_q == 32'h0 && !phy_irq_q; endproperty
  a_rs: assert property (p_rs) else $error("reset value");
  property p_sc; page_arrival_event && rd ##1 !rd ##1 rd |=> reg_rdata_q[5]; endproperty
  a_sc: assert property (p_sc) else $error("event lost");
  c_pg: cover property (page_arrival_event ##3 rd);
  c_lk: cover property ($fell(link_good));
  c_ir: cover property ($rose(phy_irq_q));
endmodule // pei_chk
bind pei_phy_event_irq pei_chk i_pei_chk (.*);
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the PHY event interrupt block
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench
module tb_top;
  logic        clock = 1'b0, rst_b = 1'b0, diag_update = 1'b0, reg_read, reg_write, reg_rvalid_q, phy_irq_q;
  logic [4:0]  reg_addr;
  logic [7:0]  ev = 8'h0;
  logic [15:0] diag_result = 16'h0;
  logic [31:0] reg_wdata, reg_rdata_q, d;
  int          fail_count = 0, n_checks = 0, cyc = 0;
  initial forever #2 clock = ~clock;
  pei_host i_pei_host (.*);
  // Link good idles high, so a one-cycle high on ev[2] is a failure
  pei_phy_event_irq i_pei_phy_event_irq (.*, .babble_event(ev[7]), .rx_fault_event(ev[6]),
    .page_arrival_event(ev[5]), .parallel_detect_fault_event(ev[4]), .partner_ack_event(ev[3]),
    .link_good(!ev[2]), .far_fault_event(ev[1]), .negotiation_done_event(ev[0]));
  task chk(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task rchk(input logic [4:0] a, input logic [31:0] e);
    i_pei_host.rd(a, d);
    chk(e, d);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clock)
    if (++cyc == 1000)
    begin
      fail_count++;
      wrap_up;
    end
  initial
  begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    rchk(5'h11, 32'h0);
    rchk(5'h12, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      i_pei_host.wr(5'h11, 32'hffff_00ff | (32'h100 << i));
      ev[i] <= 1'b1;
      @(posedge clock);
      ev <= 8'h0;
      repeat (2) @(posedge clock);
      rchk(5'h11, 32'h101 << i);
      chk(32'h1, {31'h0, phy_irq_q});
      rchk(5'h11, 32'h100 << i);
    end
    // Event lands in the very cycle the clearing read is taken
    ev <= 8'h20;
    fork
      rchk(5'h11, 32'h8000);
      begin
        @(posedge clock);
        ev <= 8'h0;
      end
    join
    rchk(5'h11, 32'h8020);
    diag_update <= 1'b1;
    diag_result <= 16'h5a3c;
    @(posedge clock);
    diag_update <= 1'b0;
    i_pei_host.wr(5'h12, 32'hffff_ffff);
    rchk(5'h12, 32'h5a3c);
    rchk(5'h1f, 32'h0);
    // Disabled flag must not raise the interrupt
    i_pei_host.wr(5'h11, 32'h0);
    ev <= 8'h01;
    @(posedge clock);
    ev <= 8'h0;
    repeat (2) @(posedge clock);
    chk(32'h0, {31'h0, phy_irq_q});
    rchk(5'h11, 32'h1);
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
